/* dv/bus_slave_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bus_slave_model (
	input  wire logic        i_clk,
	input  wire logic        i_reset,
	input  wire logic        i_bus_clock,
	input  wire logic        i_as_n,
	input  wire logic        i_rnw,
	input  wire logic        i_ext,
	input  wire logic        i_fast,
	input  wire logic [3:0]  i_waits,
	input  wire logic [31:0] i_addr,
	input  wire logic [31:0] i_data,
	output var  logic        o_ack_n,
	output var  logic [31:0] o_data,
	output var  logic        o_data_oe,
	output var  logic [31:0] o_wdata
);
	// ------------------------------------------------------------
	// bus clock edges, seen one system clock late
	// ------------------------------------------------------------
	logic       bc_q;
	logic [4:0] falls;
	logic [4:0] next_falls;
	logic       fall_e;
	logic       rise_e;
	logic       respond;

	assign fall_e = bc_q & ~i_bus_clock;
	assign rise_e = ~bc_q & i_bus_clock;
	assign next_falls = falls + 5'h01;
	// fall 1 opens the strobe phase, fall 2 the wait phase
	assign respond = fall_e & ~i_as_n
		& (next_falls == (i_fast ? 5'h01 : 5'h02 + {1'b0, i_waits}));

	// ------------------------------------------------------------
	// slave response
	// ------------------------------------------------------------
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			bc_q <= 1'b0;
			falls <= 5'h00;
			o_ack_n <= 1'b1;
			o_data <= 32'h0;
			o_data_oe <= 1'b0;
			o_wdata <= 32'h0;
		end
		else
		begin
			bc_q <= i_bus_clock;
			if (fall_e)
				falls <= i_as_n ? 5'h00 : next_falls;
			if (respond && i_ext)
				o_ack_n <= 1'b0;
			else if (rise_e)
				o_ack_n <= 1'b1;
			if (respond && i_rnw)
			begin
				o_data <= i_addr ^ 32'h5A5AA5A5;
				o_data_oe <= 1'b1;
			end
			else if (fall_e && i_as_n && o_data_oe)
			begin
				// released lines must not keep the old value
				o_data <= ~o_data;
				o_data_oe <= 1'b0;
			end
			if (rise_e && !i_as_n && !i_rnw)
				o_wdata <= i_data;
		end
	end
endmodule // bus_slave_model
`default_nettype wire

/* dv/external_bus_cycle_sequencer_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module external_bus_cycle_sequencer_bench
	import ext_bus_pkg::*;
();
	localparam int HALF = 5;
	logic              i_clk = 1'b0;
	logic              i_reset, i_req_valid, i_req_write, i_req_int_ack;
	logic              i_req_fast, o_req_ready, o_rsp_valid, o_rsp_write;
	logic [ADDR_W-1:0] i_req_addr, o_addr, e_addr;
	logic [DATA_W-1:0] i_req_wdata, o_rsp_rdata, o_data, i_data, e_wdata;
	logic [DATA_W-1:0] sl_data, sl_wdata;
	logic [TT_W-1:0]   i_req_type, o_transfer_type, e_tt;
	logic [TM_W-1:0]   i_req_modifier, o_transfer_modifier, e_tm;
	logic [SIZ_W-1:0]  i_req_width, o_transfer_width_code, e_siz;
	logic [CS_N-1:0]   i_req_cs, o_chip_select_n, e_cs;
	logic [LANES-1:0]  i_req_lanes, o_byte_lane_enable_n, e_ln;
	logic [WAIT_W-1:0] i_req_waits, sl_waits, e_w;
	logic [PF_W-1:0]   i_pin_function, e_pf;
	logic              o_bus_clock_out, o_addr_oe, o_read_not_write;
	logic              o_transfer_type_oe, o_transfer_modifier_oe;
	logic              o_transfer_in_progress_oe, o_transfer_in_progress_n;
	logic              o_transfer_start_n, o_address_strobe_n;
	logic              o_output_enable_n, o_data_oe, o_transfer_ack_n;
	logic              o_transfer_ack_oe, ack_pin, sl_ack_n, sl_oe;
	logic              sl_ext, sl_fast, e_wr, e_fast, hold_tip;
	int                error_cnt = 0;
	int                num_checks = 0;

	// wired pins: device drive wins, else the slave
	assign ack_pin = o_transfer_ack_oe ? o_transfer_ack_n : sl_ack_n;
	assign i_data = o_data_oe ? o_data : sl_data;

	always #(CLK_PERIOD_NS / 2.0) i_clk = ~i_clk;

	ext_bus_sequencer #(.HALF(HALF)) ext_bus_sequencer_inst (
		.i_clk, .i_reset, .i_req_valid, .o_req_ready, .i_req_write,
		.i_req_addr, .i_req_wdata, .i_req_type, .i_req_modifier,
		.i_req_width, .i_req_cs, .i_req_lanes, .i_req_int_ack,
		.i_req_fast, .i_req_waits, .i_pin_function, .o_rsp_valid,
		.o_rsp_write, .o_rsp_rdata, .o_bus_clock_out, .o_addr, .o_addr_oe,
		.o_read_not_write, .o_transfer_type_oe, .o_transfer_type,
		.o_transfer_modifier_oe, .o_transfer_modifier,
		.o_transfer_width_code, .o_transfer_in_progress_oe,
		.o_transfer_in_progress_n, .o_transfer_start_n,
		.o_address_strobe_n, .o_chip_select_n, .o_byte_lane_enable_n,
		.o_output_enable_n, .i_data, .o_data, .o_data_oe,
		.i_transfer_ack_n(ack_pin), .o_transfer_ack_n, .o_transfer_ack_oe
	);

	bus_slave_model bus_slave_model_inst (
		.i_clk, .i_reset, .i_bus_clock(o_bus_clock_out),
		.i_as_n(o_address_strobe_n), .i_rnw(o_read_not_write),
		.i_ext(sl_ext), .i_fast(sl_fast), .i_waits(sl_waits),
		.i_addr(o_addr), .i_data, .o_ack_n(sl_ack_n), .o_data(sl_data),
		.o_data_oe(sl_oe), .o_wdata(sl_wdata)
	);

	// ------------------------------------------------------------
	// checking helpers
	// ------------------------------------------------------------
	task automatic chk(input string name, input logic [31:0] exp,
		input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic results();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	function automatic logic [31:0] exp_rdata(input logic [31:0] a);
		return a ^ 32'h5A5AA5A5;
	endfunction

	function automatic int exp_cycles(input logic fast, input int w);
		return fast ? 2 * HALF + 1 : 4 * HALF + 2 * HALF * w + 1;
	endfunction

	// ------------------------------------------------------------
	// one transfer: request, strobe phase, answer, wind-down
	// ------------------------------------------------------------
	task automatic issue(input logic wr, fast, intk, ext,
		input logic [3:0] w);
		int n;
		e_wr = wr;
		e_fast = fast & ~intk;
		e_w = w;
		e_addr = $urandom;
		e_wdata = $urandom;
		e_tt = TT_W'($urandom);
		e_tm = TM_W'($urandom);
		e_siz = SIZ_W'($urandom);
		e_cs = CS_N'(1) << $urandom_range(CS_N - 1);
		e_ln = LANES'($urandom);
		e_pf = PF_W'($urandom);
		@(posedge i_clk);
		i_req_valid <= 1'b1;
		i_req_write <= wr;
		i_req_addr <= e_addr;
		i_req_wdata <= e_wdata;
		i_req_type <= e_tt;
		i_req_modifier <= e_tm;
		i_req_width <= e_siz;
		i_req_cs <= e_cs;
		i_req_lanes <= e_ln;
		i_req_int_ack <= intk;
		i_req_fast <= fast;
		i_req_waits <= w;
		i_pin_function <= e_pf;
		sl_ext <= ext;
		sl_fast <= fast;
		sl_waits <= w;
		for (n = 0; n < 200; n++)
		begin
			@(negedge i_clk);
			if (o_req_ready === 1'b1)
				break;
		end
		@(posedge i_clk);
		i_req_valid <= 1'b0;
	endtask

	task automatic run_check();
		int n;
		logic seen;
		seen = 1'b0;
		for (n = 1; n < 400; n++)
		begin
			@(negedge i_clk);
			if (!seen && o_address_strobe_n === 1'b0)
			begin
				seen = 1'b1;
				hold_tip = 1'b0;
				chk("address", e_addr, o_addr);
				chk("s0 attrs", 32'({e_tt, e_tm, e_siz, ~e_wr, 3'b100}),
					32'({o_transfer_type, o_transfer_modifier,
					o_transfer_width_code, o_read_not_write, o_addr_oe,
					o_transfer_in_progress_n, o_transfer_start_n}));
				chk("s1 strobes", 32'({2'b00, ~e_cs, ~e_ln, e_wr}),
					32'({o_bus_clock_out, o_address_strobe_n, o_chip_select_n,
					o_byte_lane_enable_n, o_output_enable_n}));
				chk("pin oe", 32'(e_pf), 32'({o_transfer_in_progress_oe,
					o_transfer_modifier_oe, o_transfer_type_oe}));
			end
			if (o_rsp_valid === 1'b1)
				break;
		end
		chk("cycles", exp_cycles(e_fast, int'(e_w)), n);
		chk("rsp write", 32'(e_wr), 32'(o_rsp_write));
		if (!e_wr)
			chk("read data", exp_rdata(e_addr), o_rsp_rdata);
		if (!e_fast)
			chk("s4 outputs", 32'({1'b1, e_wr}),
				32'({o_transfer_start_n, o_data_oe}));
	endtask

	task automatic fin();
		int n;
		for (n = 0; n < 400 && o_address_strobe_n !== 1'b1; n++)
			@(negedge i_clk);
		chk("s5 strobes", 32'({1'b0, {CS_N{1'b1}}, {LANES{1'b1}}, 1'b1}),
			32'({o_bus_clock_out, o_chip_select_n, o_byte_lane_enable_n,
			o_output_enable_n}));
		if (e_wr)
			chk("write data", e_wdata, sl_wdata);
		for (n = 0; n < 400 && o_transfer_in_progress_n !== 1'b1; n++)
			@(negedge i_clk);
		chk("s5 length", HALF, n);
		chk("slave released", 32'h0, 32'(sl_oe));
		chk("released", 32'h0, 32'({o_addr_oe, o_data_oe, o_transfer_type,
			o_transfer_modifier, o_transfer_width_code}));
	endtask

	always @(negedge i_clk)
		if (hold_tip)
			chk("tip held", 32'h0, 32'(o_transfer_in_progress_n));

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		logic r_wr;
		logic r_fast;
		logic r_int;
		i_reset = 1'b1;
		{i_req_valid, i_req_write, i_req_int_ack, i_req_fast} = 4'h0;
		{i_req_addr, i_req_wdata, i_req_type, i_req_modifier} = '0;
		{i_req_width, i_req_cs, i_req_lanes, i_req_waits} = '0;
		i_pin_function = 3'h0;
		{sl_ext, sl_fast, sl_waits, hold_tip} = '0;
		void'($urandom(85));
		repeat (5) @(posedge i_clk);
		i_reset <= 1'b0;
		issue(1'b0, 1'b1, 1'b0, 1'b1, 4'h0);
		run_check();
		fin();
		issue(1'b1, 1'b1, 1'b0, 1'b1, 4'h0);
		run_check();
		fin();
		issue(1'b0, 1'b0, 1'b0, 1'b1, 4'hF);
		run_check();
		fin();
		issue(1'b1, 1'b0, 1'b1, 1'b0, 4'hF);
		run_check();
		fin();
		// early external ack must not shorten an internal one
		issue(1'b0, 1'b1, 1'b1, 1'b1, 4'h0);
		run_check();
		fin();
		issue(1'b0, 1'b0, 1'b0, 1'b1, 4'h1);
		run_check();
		hold_tip = 1'b1;
		issue(1'b1, 1'b0, 1'b0, 1'b1, 4'h0);
		run_check();
		fin();
		repeat (20)
		begin
			r_wr = 1'($urandom);
			r_fast = 1'($urandom);
			r_int = 1'($urandom);
			issue(r_wr, r_fast, r_int, ~r_int, 4'($urandom_range(3)));
			run_check();
			fin();
		end
		issue(1'b1, 1'b0, 1'b0, 1'b1, 4'h3);
		repeat (3 * HALF) @(negedge i_clk);
		@(posedge i_clk);
		i_reset <= 1'b1;
		@(negedge i_clk);
		chk("reset idle", 32'({2'b11, {CS_N{1'b1}}, {LANES{1'b1}}, 6'h30}),
			32'({o_transfer_start_n, o_address_strobe_n, o_chip_select_n,
			o_byte_lane_enable_n, o_output_enable_n, o_transfer_in_progress_n,
			o_addr_oe, o_data_oe, o_rsp_valid, o_bus_clock_out}));
		@(posedge i_clk);
		i_reset <= 1'b0;
		issue(1'b0, 1'b0, 1'b0, 1'b1, 4'h0);
		run_check();
		fin();
		results();
	end

	initial
	begin
		#(CLK_PERIOD_NS * 20000);
		error_cnt++;
		$display("ERROR watchdog expected done seen hang");
		results();
	end
endmodule // external_bus_cycle_sequencer_bench
`default_nettype wire

/* src/bus_phase_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module bus_phase_timer
	import ext_bus_pkg::*;
#(
	parameter int HALF = HALF_CYCLES
)(
	input  wire logic i_clk,
	input  wire logic i_reset,
	output var  logic o_bus_clock,
	output logic      o_rise,
	output logic      o_fall
);

	localparam int CW = (HALF > 1) ? $clog2(HALF) : 1;
	localparam logic [CW-1:0] LAST = CW'(HALF - 1);

	logic [CW-1:0] count;
	wire           term = (count == LAST);

	// tick marks the cycle whose edge flips the bus clock
	assign o_rise = term && !o_bus_clock;
	assign o_fall = term && o_bus_clock;

	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			count       <= '0;
			o_bus_clock <= 1'b0;
		end
		else
		begin
			count <= term ? '0 : count + CW'(1);
			if (term)
				o_bus_clock <= !o_bus_clock;
		end
	end

endmodule // bus_phase_timer
`default_nettype wire

/* src/ext_bus_pkg.sv */
`default_nettype none
package ext_bus_pkg;

	// ------------------------------------------------------------
	// widths
	// ------------------------------------------------------------
	localparam int ADDR_W  = 32;
	localparam int DATA_W  = 32;
	localparam int CS_N    = 8;
	localparam int LANES   = 4;
	localparam int TT_W    = 2;
	localparam int TM_W    = 3;
	localparam int SIZ_W   = 2;
	localparam int WAIT_W  = 4;
	localparam int PF_W    = 3;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 5;
	localparam int BUS_PERIOD_NS = 50;
	// longest half phase, rounded down, never below one cycle
	localparam int HALF_CYCLES_RAW = BUS_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam int HALF_CYCLES = (HALF_CYCLES_RAW < 1) ? 1 : HALF_CYCLES_RAW;

	// ------------------------------------------------------------
	// pin function select bit positions
	// ------------------------------------------------------------
	localparam int PF_TYPE     = 0;
	localparam int PF_MODIFIER = 1;
	localparam int PF_TIP      = 2;

	// ------------------------------------------------------------
	// reset / idle values
	// ------------------------------------------------------------
	localparam logic [TT_W-1:0]  TT_IDLE  = 2'h0;
	localparam logic [TM_W-1:0]  TM_IDLE  = 3'h0;
	localparam logic [SIZ_W-1:0] SIZ_IDLE = 2'h0;
	localparam logic [ADDR_W-1:0] ADDR_IDLE = 32'h0;
	localparam logic [DATA_W-1:0] DATA_IDLE = 32'h0;

	typedef enum logic [2:0] {
		ST_IDLE, ST_S0, ST_S1, ST_S2, ST_S3, ST_S4, ST_S5
	} bus_state_t;

endpackage
`default_nettype wire

/* src/ext_bus_sequencer.sv */
// Summary of operation
// - even states high phase, odd low
// - six states; fast skips two and three
// - state 0: address, in-progress, read/write
// - state 0: type, modifier, width, start
// - state 1 fall: strobe, selects, enables
// - fast: ack in state 1, go state 4
// - state 2 rise: negate start
// - write: drive data at state 2
// - state 3: whole-clock waits until acknowledged
// - read data captured only with ack
// - state 5 fall: negate strobe, selects, enables
// - end state 5: release address, attributes
// - back-to-back keeps in-progress asserted
// - write: data released ending state 5
// - internal ack same waveform as external
// - type, modifier, progress pins need selecting
// - per-access internal or external ack
// - no fast termination with internal ack
`timescale 1ns/1ps
`default_nettype none
module ext_bus_sequencer
	import ext_bus_pkg::*;
#(
	parameter int HALF = HALF_CYCLES
)(
	input  wire logic              i_clk,
	input  wire logic              i_reset,
	input  wire logic              i_req_valid,
	output logic                   o_req_ready,
	input  wire logic              i_req_write,
	input  wire logic [ADDR_W-1:0] i_req_addr,
	input  wire logic [DATA_W-1:0] i_req_wdata,
	input  wire logic [TT_W-1:0]   i_req_type,
	input  wire logic [TM_W-1:0]   i_req_modifier,
	input  wire logic [SIZ_W-1:0]  i_req_width,
	input  wire logic [CS_N-1:0]   i_req_cs,
	input  wire logic [LANES-1:0]  i_req_lanes,
	input  wire logic              i_req_int_ack,
	input  wire logic              i_req_fast,
	input  wire logic [WAIT_W-1:0] i_req_waits,
	input  wire logic [PF_W-1:0]   i_pin_function,
	output var  logic              o_rsp_valid,
	output var  logic              o_rsp_write,
	output var  logic [DATA_W-1:0] o_rsp_rdata,
	output logic                   o_bus_clock_out,
	output var  logic [ADDR_W-1:0] o_addr,
	output var  logic              o_addr_oe,
	output var  logic              o_read_not_write,
	output logic                   o_transfer_type_oe,
	output var  logic [TT_W-1:0]   o_transfer_type,
	output logic                   o_transfer_modifier_oe,
	output var  logic [TM_W-1:0]   o_transfer_modifier,
	output var  logic [SIZ_W-1:0]  o_transfer_width_code,
	output logic                   o_transfer_in_progress_oe,
	output var  logic              o_transfer_in_progress_n,
	output var  logic              o_transfer_start_n,
	output var  logic              o_address_strobe_n,
	output var  logic [CS_N-1:0]   o_chip_select_n,
	output var  logic [LANES-1:0]  o_byte_lane_enable_n,
	output var  logic              o_output_enable_n,
	input  wire logic [DATA_W-1:0] i_data,
	output var  logic [DATA_W-1:0] o_data,
	output var  logic              o_data_oe,
	input  wire logic              i_transfer_ack_n,
	output logic                   o_transfer_ack_n,
	output var  logic              o_transfer_ack_oe
);

	// ------------------------------------------------------------
	// phase timing
	// ------------------------------------------------------------
	logic rise;
	logic fall;

	bus_phase_timer #(.HALF(HALF)) u_timer (
		.i_clk       (i_clk),
		.i_reset     (i_reset),
		.o_bus_clock (o_bus_clock_out),
		.o_rise      (rise),
		.o_fall      (fall)
	);

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic              ack_meta;
	logic              ack_sync;
	logic [DATA_W-1:0] data_meta;
	logic [DATA_W-1:0] data_sync;

	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			ack_meta  <= 1'b1;
			ack_sync  <= 1'b1;
			data_meta <= DATA_IDLE;
			data_sync <= DATA_IDLE;
		end
		else
		begin
			ack_meta  <= i_transfer_ack_n;
			ack_sync  <= ack_meta;
			data_meta <= i_data;
			data_sync <= data_meta;
		end
	end

	// ------------------------------------------------------------
	// sequencing
	// ------------------------------------------------------------
	bus_state_t        state;
	bus_state_t        next_state;
	logic              write_q;
	logic              int_q;
	logic              fast_q;
	logic [DATA_W-1:0] wdata_q;
	logic [CS_N-1:0]   cs_q;
	logic [LANES-1:0]  lanes_q;
	logic [WAIT_W-1:0] wait_cnt;

	function automatic logic is_even(input bus_state_t s);
		return (s == ST_S0) || (s == ST_S2) || (s == ST_S4);
	endfunction

	function automatic logic is_odd(input bus_state_t s);
		return (s == ST_S1) || (s == ST_S3) || (s == ST_S5);
	endfunction

	// internal ack bypasses the pin synchroniser, seen two clocks sooner
	wire ext_ack   = !ack_sync;
	wire ack_seen  = int_q ? o_transfer_ack_oe : ext_ack;
	// fast termination is ignored when ack is internal
	wire fast_done = fast_q && !int_q && ext_ack;
	wire slot_free = (state == ST_IDLE) || (state == ST_S5);
	wire take      = rise && slot_free && i_req_valid;
	wire done      = rise && (((state == ST_S1) && fast_done)
	                 || ((state == ST_S3) && ack_seen));
	wire finish    = rise && (state == ST_S5) && !i_req_valid;
	wire ack_due   = fall && int_q && (wait_cnt == '0)
	                 && ((state == ST_S2) || (state == ST_S3));

	assign o_req_ready = rise && slot_free;
	assign o_transfer_ack_n = 1'b0;
	// attribute pins float unless routed to this function
	assign o_transfer_type_oe        = i_pin_function[PF_TYPE];
	assign o_transfer_modifier_oe    = i_pin_function[PF_MODIFIER];
	assign o_transfer_in_progress_oe = i_pin_function[PF_TIP];

	always_comb
	begin
		next_state = state;
		case (state)
			ST_IDLE: if (take) next_state = ST_S0;
			ST_S0:   if (fall) next_state = ST_S1;
			ST_S1:   if (rise)
				next_state = fast_done ? ST_S4 : ST_S2;
			ST_S2:   if (fall) next_state = ST_S3;
			// a miss replays S2 and S3: one whole clock, phases kept
			ST_S3:
				if (done)
					next_state = ST_S4;
				else if (rise)
					next_state = ST_S2;
			ST_S4:   if (fall) next_state = ST_S5;
			ST_S5:   if (rise)
				next_state = i_req_valid ? ST_S0 : ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	// ------------------------------------------------------------
	// request capture and rising-edge attributes
	// ------------------------------------------------------------
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			write_q  <= 1'b0;
			int_q    <= 1'b0;
			fast_q   <= 1'b0;
			wdata_q  <= DATA_IDLE;
			cs_q     <= '0;
			lanes_q  <= '0;
			o_addr   <= ADDR_IDLE;
			o_addr_oe <= 1'b0;
			o_read_not_write <= 1'b1;
			o_transfer_type  <= TT_IDLE;
			o_transfer_modifier <= TM_IDLE;
			o_transfer_width_code <= SIZ_IDLE;
			o_transfer_in_progress_n <= 1'b1;
			o_transfer_start_n <= 1'b1;
		end
		else if (take)
		begin
			write_q  <= i_req_write;
			int_q    <= i_req_int_ack;
			fast_q   <= i_req_fast;
			wdata_q  <= i_req_wdata;
			cs_q     <= i_req_cs;
			lanes_q  <= i_req_lanes;
			o_addr   <= i_req_addr;
			o_addr_oe <= 1'b1;
			o_read_not_write <= !i_req_write;
			o_transfer_in_progress_n <= 1'b0;
			o_transfer_type  <= i_req_type;
			o_transfer_modifier <= i_req_modifier;
			o_transfer_width_code <= i_req_width;
			o_transfer_start_n <= 1'b0;
		end
		else if (finish)
		begin
			// read/write level is kept, only released
			o_addr_oe <= 1'b0;
			o_transfer_type  <= TT_IDLE;
			o_transfer_modifier <= TM_IDLE;
			o_transfer_width_code <= SIZ_IDLE;
			o_transfer_in_progress_n <= 1'b1;
		end
		else if (rise && (state == ST_S1))
			o_transfer_start_n <= 1'b1;
	end

	// ------------------------------------------------------------
	// falling-edge strobes
	// ------------------------------------------------------------
	wire strobe_on  = fall && (state == ST_S0);
	wire strobe_off = fall && (state == ST_S4);

	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			o_address_strobe_n   <= 1'b1;
			o_chip_select_n      <= '1;
			o_byte_lane_enable_n <= '1;
			o_output_enable_n    <= 1'b1;
		end
		else if (strobe_on)
		begin
			o_address_strobe_n   <= 1'b0;
			o_chip_select_n      <= ~cs_q;
			o_byte_lane_enable_n <= ~lanes_q;
			o_output_enable_n    <= write_q;
		end
		else if (strobe_off)
		begin
			o_address_strobe_n   <= 1'b1;
			o_chip_select_n      <= '1;
			o_byte_lane_enable_n <= '1;
			o_output_enable_n    <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// data bus, acknowledge and completion
	// ------------------------------------------------------------
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			o_data      <= DATA_IDLE;
			o_data_oe   <= 1'b0;
			o_rsp_valid <= 1'b0;
			o_rsp_write <= 1'b0;
			o_rsp_rdata <= DATA_IDLE;
		end
		else
		begin
			o_rsp_valid <= done;
			if (rise && (state == ST_S1) && write_q)
			begin
				o_data    <= wdata_q;
				o_data_oe <= 1'b1;
			end
			else if (rise && (state == ST_S5))
				o_data_oe <= 1'b0;
			if (done)
			begin
				o_rsp_write <= write_q;
				if (!write_q)
					o_rsp_rdata <= data_sync;
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			wait_cnt <= '0;
			o_transfer_ack_oe <= 1'b0;
		end
		else if (take)
			wait_cnt <= i_req_waits;
		else if (ack_due)
			o_transfer_ack_oe <= 1'b1;
		else if (done)
			o_transfer_ack_oe <= 1'b0;
		else if (rise && (state == ST_S3) && (wait_cnt != '0))
			wait_cnt <= wait_cnt - WAIT_W'(1);
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	property p_phase_match;
		(is_even(state) |-> o_bus_clock_out)
		and (is_odd(state) |-> !o_bus_clock_out);
	endproperty
	a_phase_match: assert property (p_phase_match)
		else $error("state phase does not match bus clock");

	property p_open;
		take |=> !o_transfer_in_progress_n && o_addr_oe
		&& (o_read_not_write == !$past(i_req_write))
		&& (o_addr == $past(i_req_addr)) && (state == ST_S0);
	endproperty
	a_open: assert property (p_open)
		else $error("state 0 attributes wrong");

	property p_start_width;
		take |=> !o_transfer_start_n
		&& (o_transfer_width_code == $past(i_req_width));
	endproperty
	a_start_width: assert property (p_start_width)
		else $error("start or width not driven at state 0");

	property p_strobe_on;
		strobe_on |=> !o_address_strobe_n && (state == ST_S1)
		&& (o_chip_select_n == ~cs_q);
	endproperty
	a_strobe_on: assert property (p_strobe_on)
		else $error("strobe not asserted entering state 1");

	property p_fast;
		(rise && (state == ST_S1) && fast_done)
		|=> (state == ST_S4) && o_rsp_valid;
	endproperty
	a_fast: assert property (p_fast)
		else $error("fast termination did not reach state 4");

	property p_start_off;
		(state == ST_S2) |-> o_transfer_start_n;
	endproperty
	a_start_off: assert property (p_start_off)
		else $error("start still asserted in state 2");

	property p_wdata;
		((state == ST_S2) && write_q) |-> o_data_oe && (o_data == wdata_q);
	endproperty
	a_wdata: assert property (p_wdata)
		else $error("write data not driven in state 2");

	property p_wait;
		(rise && (state == ST_S3) && !ack_seen)
		|=> (state == ST_S2) && o_bus_clock_out;
	endproperty
	a_wait: assert property (p_wait)
		else $error("left state 3 without acknowledge");

	property p_strobe_off;
		(state == ST_S5) |-> o_address_strobe_n && o_output_enable_n
		&& (o_chip_select_n == '1) && (o_byte_lane_enable_n == '1);
	endproperty
	a_strobe_off: assert property (p_strobe_off)
		else $error("strobes still active in state 5");

	property p_end;
		finish |=> o_transfer_in_progress_n && !o_addr_oe && !o_data_oe
		&& (state == ST_IDLE);
	endproperty
	a_end: assert property (p_end)
		else $error("cycle end left signals driven");

	property p_no_fast_int;
		(rise && (state == ST_S1) && int_q) |=> (state == ST_S2);
	endproperty
	a_no_fast_int: assert property (p_no_fast_int)
		else $error("fast termination taken with internal ack");

	c_read_wait: cover property (rise && (state == ST_S3) && !ack_seen
		&& !write_q);
	c_fast_write: cover property (done && (state == ST_S1) && write_q);
	c_back_to_back: cover property (take && (state == ST_S5));
	c_internal: cover property (done && int_q);

endmodule // ext_bus_sequencer
`default_nettype wire
